// file: rtl/move_and_indirect_access_ops.v
// execution of move, indirect pointer and control instructions
// assumes fetch holds instr_data while instr_valid is high and
// data memory answers a read with mem_rdata one cycle later
//
// Functional notes
// RULE1: indirect load reads pointer target, sets zero
// RULE2: mode field 00/01/10/11 pre/pre/post/post inc-dec
// RULE3: pre modes update pointer then use it
// RULE4: offset -32..31 added, pointer kept
// RULE5: pointer ends one up or down
// RULE6: pointer wraps at 16 bits
// RULE7: indirect locations map to pointer target
// RULE8: indirect store writes acc, flags kept
// RULE9: pointer updates never touch status flags
// RULE10: bank literal load, flags kept
// RULE11: eight-bit literal to acc, one cycle
// RULE12: acc to file register, one cycle
// RULE13: acc to option register, one cycle
// RULE14: reset instruction resets device, clears flag
// RULE15: no operation changes nothing, one cycle
//
// Local design decisions: the address-and-strobe port and the address map.
`include "move_ops_defs.vh"

module move_and_indirect_access_ops #(
    parameter PTR_W = 16,
    parameter OFS_W = 6
) (
    ref_clk,
    resetn,
    instr_valid,
    instr_data,
    instr_ready_q,
    mem_addr_q,
    mem_wdata_q,
    mem_we_q,
    mem_re_q,
    mem_rdata,
    acc_q,
    zero_flag_q,
    bank_q,
    option_q,
    soft_reset_q,
    reset_instruction_flag_n,
    reg_addr,
    reg_wdata,
    reg_we,
    reg_re,
    reg_rdata_q
);
    // --------
    // ports
    // --------
    input  wire              ref_clk;        // core clock, 50 MHz
    input  wire              resetn;         // sync reset, low
    input  wire              instr_valid;    // opcode offered
    input  wire [13:0]       instr_data;     // opcode word
    output reg               instr_ready_q;  // opcode taken if high
    output reg  [PTR_W-1:0]  mem_addr_q;     // data address
    output reg  [7:0]        mem_wdata_q;    // data to write
    output reg               mem_we_q;       // write strobe
    output reg               mem_re_q;       // read strobe
    input  wire [7:0]        mem_rdata;      // read data, next cycle
    output reg  [7:0]        acc_q;          // working register
    output reg               zero_flag_q;    // zero status flag
    output reg  [4:0]        bank_q;         // bank select register
    output reg  [7:0]        option_q;       // timer/option register
    output wire              soft_reset_q;   // reset pulse, from flop
    output wire              reset_instruction_flag_n; // from flop
    input  wire [3:0]        reg_addr;       // register port address
    input  wire [7:0]        reg_wdata;      // register write data
    input  wire              reg_we;         // register write strobe
    input  wire              reg_re;         // register read strobe
    output reg  [7:0]        reg_rdata_q;    // read data, next cycle

    // --------
    // states, one-hot
    // --------
    localparam [2:0] ST_IDLE  = 3'h1;  // taking opcodes
    localparam [2:0] ST_ISSUE = 3'h2;  // read strobe out
    localparam [2:0] ST_CATCH = 3'h4;  // read data back

    // --------
    // registers
    // --------
    reg  [2:0]       state_q;          // sequencer state
    reg  [2:0]       state_d;          // next state
    reg  [PTR_W-1:0] ptr0_q;           // indirect_pointer 0
    reg  [PTR_W-1:0] ptr1_q;           // indirect_pointer 1
    reg  [PTR_W-1:0] ptr0_d;           // next pointer 0
    reg  [PTR_W-1:0] ptr1_d;           // next pointer 1
    reg  [7:0]       acc_d;            // next working register
    reg              zero_d;           // next zero flag
    reg  [4:0]       bank_d;           // next bank select
    reg  [7:0]       option_d;         // next option
    reg  [PTR_W-1:0] addr_d;           // next data address
    reg  [7:0]       wdata_d;          // next write data
    reg              we_d;             // next write strobe
    reg              re_d;             // next read strobe
    reg              ready_d;          // next ready
    reg              reset_op;         // reset instruction taken
    reg              power_control_status_reg_set;         // software sets flag

    // --------
    // opcode fields
    // --------
    wire        take    = instr_valid & instr_ready_q; // opcode accepted
    wire [13:0] op      = instr_data;                   // short alias
    // short pointer form: mode field in the low bits
    wire        ind_op  = (op[13:4] == `OPC_IND_TOP);
    // offset form: signed six-bit offset in the low bits
    wire        rel_op  = (op[13:8] == `OPC_REL_TOP);
    wire        ind_any = ind_op | rel_op;             // any pointer move
    wire        is_st   = ind_op ? op[3] : op[7];      // store, else load
    wire        sel     = ind_op ? op[2] : op[6];      // pointer select
    wire [1:0]  pointer_mode_field = op[1:0];          // RULE2
    wire [OFS_W-1:0] offset = op[OFS_W-1:0];           // RULE4
    wire        bank_literal_load_op = (op[13:5] == `OPC_BANK_TOP);
    wire        literal_to_acc_op    = (op[13:8] == `OPC_LIT_TOP);
    wire        acc_to_file_op       = (op[13:7] == `OPC_WF_TOP);
    wire        option_op            = (op == `OPC_OPTION);
    wire        sw_reset_op          = (op == `OPC_RESET);
    wire        no_operation_op      = (op == `OPC_NOP);
    wire [6:0]  file_addr            = op[6:0];        // RULE12

    // indirect_load_op and indirect_store_op, both forms
    wire indirect_load_op  = ind_any & ~is_st;
    wire indirect_store_op = ind_any &  is_st;

    // --------
    // pointer arithmetic, one unit per pointer
    // --------
    wire [PTR_W-1:0] eff0;   // address via pointer 0
    wire [PTR_W-1:0] eff1;   // address via pointer 1
    wire [PTR_W-1:0] nxt0;   // pointer 0 after move
    wire [PTR_W-1:0] nxt1;   // pointer 1 after move

    pointer_unit #(
        .PTR_W (PTR_W),
        .OFS_W (OFS_W)
    ) u_ptr0 (
        .ptr      (ptr0_q),
        .mode     (pointer_mode_field),
        .offset   (offset),
        .rel      (rel_op),
        .eff_addr (eff0),
        .ptr_next (nxt0)
    );

    pointer_unit #(
        .PTR_W (PTR_W),
        .OFS_W (OFS_W)
    ) u_ptr1 (
        .ptr      (ptr1_q),
        .mode     (pointer_mode_field),
        .offset   (offset),
        .rel      (rel_op),
        .eff_addr (eff1),
        .ptr_next (nxt1)
    );

    // chosen pointer's effective address
    wire [PTR_W-1:0] eff_sel = sel ? eff1 : eff0;      // RULE1

    // file address in the current bank, zero-extended
    wire [PTR_W-1:0] bank_addr =
        {{(PTR_W-`BANK_W-`FILE_W){1'b0}}, bank_q, file_addr};

    // --------
    // soft reset and reset-instruction flag
    // --------
    reset_flag_keeper u_rst (
        .ref_clk                  (ref_clk),
        .resetn                   (resetn),
        .reset_op                 (reset_op),
        .sw_set                   (power_control_status_reg_set),
        .soft_reset_q             (soft_reset_q),
        .reset_instruction_flag_n (reset_instruction_flag_n)
    );

    // core register reset: power-on or the software reset pulse; reg_rdata_q and the reset flag see resetn only
    wire core_rst = ~resetn | soft_reset_q;            // RULE14

    // --------
    // execute, next-state logic
    // --------
    // nothing changes unless an opcode or a register write says so, so the zero flag is only
    // written here by the indirect load
    always @* begin
        state_d  = state_q;
        ptr0_d   = ptr0_q;
        ptr1_d   = ptr1_q;
        acc_d    = acc_q;
        zero_d   = zero_flag_q;                        // RULE9
        bank_d   = bank_q;
        option_d = option_q;
        addr_d   = mem_addr_q;
        wdata_d  = mem_wdata_q;
        we_d     = 1'b0;
        re_d     = 1'b0;
        ready_d  = instr_ready_q;
        reset_op = 1'b0;
        power_control_status_reg_set = 1'b0;

        // software writes first, so an instruction below wins
        if (reg_we) begin
            case (reg_addr)
                `RA_BANK:    bank_d   = reg_wdata[4:0];
                `RA_OPTION:  option_d = reg_wdata;
                `RA_PTR0_LO: ptr0_d   = {ptr0_q[PTR_W-1:8], reg_wdata};
                `RA_PTR0_HI: ptr0_d   = {reg_wdata, ptr0_q[7:0]};
                `RA_PTR1_LO: ptr1_d   = {ptr1_q[PTR_W-1:8], reg_wdata};
                `RA_PTR1_HI: ptr1_d   = {reg_wdata, ptr1_q[7:0]};
                `RA_POWER_CONTROL_STATUS_REG:    power_control_status_reg_set = reg_wdata[0];
                default: begin
                    // read-only or unmapped: ignored
                end
            endcase
        end

        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    if (ind_any) begin
                        // pointer moves, status untouched
                        if (sel) begin
                            ptr1_d = nxt1;             // RULE5 RULE9
                        end else begin
                            ptr0_d = nxt0;             // RULE5 RULE9
                        end
                        addr_d = eff_sel;              // RULE3 RULE4
                    end
                    if (indirect_store_op) begin
                        wdata_d = acc_q;               // RULE8
                        we_d    = 1'b1;                // RULE8
                    end else if (indirect_load_op) begin
                        // two more cycles for the memory read
                        re_d    = 1'b1;                // RULE1
                        ready_d = 1'b0;
                        state_d = ST_ISSUE;
                    end else if (bank_literal_load_op) begin
                        bank_d = op[4:0];              // RULE10
                    end else if (literal_to_acc_op) begin
                        acc_d = op[7:0];               // RULE11
                    end else if (acc_to_file_op) begin
                        // indirect locations hold nothing themselves
                        if (file_addr == `IND_LOC0) begin
                            addr_d = ptr0_q;           // RULE7
                        end else if (file_addr == `IND_LOC1) begin
                            addr_d = ptr1_q;           // RULE7
                        end else begin
                            addr_d = bank_addr;        // RULE12
                        end
                        wdata_d = acc_q;               // RULE12
                        we_d    = 1'b1;                // RULE12
                    end else if (option_op) begin
                        option_d = acc_q;              // RULE13
                    end else if (sw_reset_op) begin
                        reset_op = 1'b1;               // RULE14
                    end else if (no_operation_op) begin
                        // one cycle, nothing written     RULE15
                    end else begin
                        // opcodes of other units: no effect here
                    end
                end
            end
            ST_ISSUE: begin
                // read strobe is out, data comes next cycle
                state_d = ST_CATCH;
            end
            ST_CATCH: begin
                // memory answers; ready only back now
                acc_d   = mem_rdata;                   // RULE1
                zero_d  = (mem_rdata == 8'h00);        // RULE1
                state_d = ST_IDLE;
                ready_d = 1'b1;
            end
            default: begin
                // illegal code: recover to idle
                state_d = ST_IDLE;
                ready_d = 1'b1;
            end
        endcase
    end

    // --------
    // state registers
    // --------
    // the soft reset pulse clears the core exactly like power-on
    always @(posedge ref_clk) begin
        if (core_rst) begin
            state_q       <= ST_IDLE;
            ptr0_q        <= `RST_PTR;
            ptr1_q        <= `RST_PTR;
            acc_q         <= `RST_ACC;
            zero_flag_q   <= 1'b0;
            bank_q        <= `RST_BANK;
            option_q      <= `RST_OPTION;
            mem_addr_q    <= `RST_PTR;
            mem_wdata_q   <= 8'h00;
            mem_we_q      <= 1'b0;
            mem_re_q      <= 1'b0;
            instr_ready_q <= 1'b0;
        end else begin
            state_q       <= state_d;
            ptr0_q        <= ptr0_d;
            ptr1_q        <= ptr1_d;
            acc_q         <= acc_d;
            zero_flag_q   <= zero_d;
            bank_q        <= bank_d;
            option_q      <= option_d;
            mem_addr_q    <= addr_d;
            mem_wdata_q   <= wdata_d;
            mem_we_q      <= we_d;
            mem_re_q      <= re_d;
            // ready rises on the first edge out of reset
            instr_ready_q <= (state_q == ST_IDLE) & ~take ? 1'b1
                                                         : ready_d;
        end
    end

    // --------
    // register port read side
    // --------
    // read data stands in the cycle after the strobe only
    always @(posedge ref_clk) begin
        if (!resetn) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_re) begin
            case (reg_addr)
                `RA_ACC:     reg_rdata_q <= acc_q;
                `RA_STATUS:  reg_rdata_q <= {7'h00, zero_flag_q};
                `RA_BANK:    reg_rdata_q <= {3'h0, bank_q};
                `RA_OPTION:  reg_rdata_q <= option_q;
                `RA_PTR0_LO: reg_rdata_q <= ptr0_q[7:0];
                `RA_PTR0_HI: reg_rdata_q <= ptr0_q[PTR_W-1:8];
                `RA_PTR1_LO: reg_rdata_q <= ptr1_q[7:0];
                `RA_PTR1_HI: reg_rdata_q <= ptr1_q[PTR_W-1:8];
                `RA_POWER_CONTROL_STATUS_REG:    reg_rdata_q <= {7'h00, reset_instruction_flag_n};
                default:     reg_rdata_q <= 8'h00;
            endcase
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end
endmodule // move_and_indirect_access_ops

// file: rtl/move_ops_defs.vh
// constants for the move / indirect access execution block
// assumes 14-bit opcodes and a 16-bit data address space
`ifndef MOVE_OPS_DEFS_VH
`define MOVE_OPS_DEFS_VH

// --------
// widths
// --------
`define BANK_W      5
`define FILE_W      7

// --------
// opcode patterns
// --------
`define OPC_IND_TOP   10'h001
`define OPC_REL_TOP   6'h3f
`define OPC_BANK_TOP  9'h001
`define OPC_LIT_TOP   6'h30
`define OPC_WF_TOP    7'h01
`define OPC_NOP       14'h0000
`define OPC_RESET     14'h0001
`define OPC_OPTION    14'h0062

// --------
// pointer mode field codes
// --------
`define MODE_PREINC   2'h0
`define MODE_PREDEC   2'h1
`define MODE_POSTINC  2'h2
`define MODE_POSTDEC  2'h3

// --------
// file addresses that stand for the pointers
// --------
`define IND_LOC0      7'h00
`define IND_LOC1      7'h01

// --------
// register port offsets
// --------
`define RA_ACC        4'h0
`define RA_STATUS     4'h1
`define RA_BANK       4'h2
`define RA_OPTION     4'h3
`define RA_PTR0_LO    4'h4
`define RA_PTR0_HI    4'h5
`define RA_PTR1_LO    4'h6
`define RA_PTR1_HI    4'h7
`define RA_POWER_CONTROL_STATUS_REG       4'h8

// --------
// reset values
// --------
`define RST_ACC       8'h00
`define RST_BANK      5'h00
`define RST_OPTION    8'hff
`define RST_PTR       16'h0000

`endif

// file: rtl/pointer_unit.v
// address and update arithmetic for one indirect pointer
// assumes the caller registers the next pointer value
`include "move_ops_defs.vh"
module pointer_unit #(
    parameter PTR_W = 16,
    parameter OFS_W = 6
) (
    ptr,
    mode,
    offset,
    rel,
    eff_addr,
    ptr_next
);
    input  wire [PTR_W-1:0] ptr;       // current pointer
    input  wire [1:0]       mode;      // pointer mode field
    input  wire [OFS_W-1:0] offset;    // signed offset
    input  wire             rel;       // offset form
    output reg  [PTR_W-1:0] eff_addr;  // address used
    output reg  [PTR_W-1:0] ptr_next;  // pointer after move

    // --------
    // arithmetic
    // --------
    // widths equal to the pointer so the sums wrap by themselves
    wire [PTR_W-1:0] inc  = ptr + {{(PTR_W-1){1'b0}}, 1'b1};      // RULE6
    wire [PTR_W-1:0] dec  = ptr - {{(PTR_W-1){1'b0}}, 1'b1};      // RULE6
    wire [PTR_W-1:0] sext = {{(PTR_W-OFS_W){offset[OFS_W-1]}}, offset};
    wire [PTR_W-1:0] sum  = ptr + sext;                            // RULE4

    // --------
    // mode select
    // --------
    always @* begin
        eff_addr = ptr;
        ptr_next = ptr;
        if (rel) begin
            eff_addr = sum;                                        // RULE4
        end else begin
            case (mode)
                `MODE_PREINC: begin
                    eff_addr = inc;                                // RULE3
                    ptr_next = inc;                                // RULE5
                end
                `MODE_PREDEC: begin
                    eff_addr = dec;                                // RULE3
                    ptr_next = dec;                                // RULE5
                end
                `MODE_POSTINC: begin
                    ptr_next = inc;                                // RULE5
                end
                default: begin
                    ptr_next = dec;                                // RULE5
                end
            endcase
        end
    end
endmodule // pointer_unit

// file: rtl/reset_flag_keeper.v
// software reset pulse and the active-low reset-instruction flag
// assumes one clock and a synchronous active-low power-on reset
module reset_flag_keeper (
    ref_clk,
    resetn,
    reset_op,
    sw_set,
    soft_reset_q,
    reset_instruction_flag_n
);
    input  wire ref_clk;                   // core clock
    input  wire resetn;                    // power-on reset, low
    input  wire reset_op;                  // reset instruction taken
    input  wire sw_set;                    // software writes flag to 1
    output reg  soft_reset_q;              // one-cycle device reset
    output reg  reset_instruction_flag_n;  // low after reset instruction

    // --------
    // flag and pulse
    // --------
    // flag survives the soft reset it reports, so only resetn or a software set returns it high
    always @(posedge ref_clk) begin
        if (!resetn) begin
            soft_reset_q             <= 1'b0;
            reset_instruction_flag_n <= 1'b1;
        end else begin
            soft_reset_q <= reset_op;                      // RULE14
            // the instruction wins over a software set in the same cycle
            if (reset_op) begin
                reset_instruction_flag_n <= 1'b0;          // RULE14
            end else if (sw_set) begin
                reset_instruction_flag_n <= 1'b1;
            end
        end
    end
endmodule // reset_flag_keeper

// file: tb/move_ops_chk.sv
// concurrent checks on the move / indirect access block ports
// assumes one clock and a synchronous active-low reset
module move_ops_chk (
    input wire logic        ref_clk, resetn, instr_valid, instr_ready_q,
    input wire logic [13:0] instr_data,
    input wire logic [15:0] mem_addr_q,
    input wire logic [7:0]  mem_wdata_q, mem_rdata, acc_q, option_q,
    input wire logic        mem_we_q, mem_re_q, zero_flag_q, soft_reset_q,
    input wire logic        reset_instruction_flag_n,
    input wire logic [4:0]  bank_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // --------
    // decode of the opcode taken this edge
    // --------
    wire        take = instr_valid && instr_ready_q;
    wire [13:0] op   = instr_data;
    wire        rel  = op[13:8] == 6'h3f;                     // offset form
    wire        ind  = take && (op[13:4] == 10'h001 || rel);
    wire        st   = ind && (rel ? op[7] : op[3]);          // store bit
    wire        ld   = ind && !st;
    property p_lit; take && op[13:8] == 6'h30 |=> acc_q == $past(instr_data[7:0]) && $stable(zero_flag_q); endproperty
    a_lit: assert property (p_lit) else $error("literal load wrong");
    property p_bank; take && op[13:5] == 9'h001 |=> bank_q == $past(instr_data[4:0]) && $stable(zero_flag_q); endproperty
    a_bank: assert property (p_bank) else $error("bank load wrong");
    property p_opt; take && op == 14'h0062 |=> option_q == $past(acc_q); endproperty
    a_opt: assert property (p_opt) else $error("option load wrong");
    // files 0 and 1 go through a pointer: strobe and data only
    property p_file; take && op[13:7] == 7'h01 |=> mem_we_q && mem_wdata_q == $past(acc_q)
        && (mem_addr_q == {4'h0, $past(bank_q), $past(instr_data[6:0])} || $past(instr_data[6:1]) == 6'h00); endproperty
    a_file: assert property (p_file) else $error("file move wrong");
    property p_st; st |=> mem_we_q && !mem_re_q && mem_wdata_q == $past(acc_q) && $stable(zero_flag_q); endproperty
    a_st: assert property (p_st) else $error("indirect store wrong");
    property p_ld; ld |=> mem_re_q && !instr_ready_q ##1 !mem_re_q && !instr_ready_q
        ##1 acc_q == $past(mem_rdata) && zero_flag_q == (acc_q == 8'h00);
    endproperty
    a_ld: assert property (p_ld) else $error("indirect load wrong");
    property p_ldz; ld |=> $stable(zero_flag_q)[*2]; endproperty
    a_ldz: assert property (p_ldz) else $error("flag moved by pointer step");
    property p_idle; take && op == 14'h0000 |=> !mem_we_q && !mem_re_q && $stable(acc_q); endproperty
    a_idle: assert property (p_idle) else $error("idle opcode had effect");
    property p_rst; take && op == 14'h0001 |=> soft_reset_q && !reset_instruction_flag_n
        ##1 acc_q == 8'h00 && option_q == 8'hff && bank_q == 5'h00; endproperty
    a_rst: assert property (p_rst) else $error("software reset wrong");
endmodule // move_ops_chk

bind move_and_indirect_access_ops move_ops_chk u_chk (.ref_clk, .resetn, .instr_valid, .instr_ready_q, .instr_data,
    .mem_addr_q, .mem_wdata_q, .mem_rdata, .acc_q, .option_q, .mem_we_q, .mem_re_q, .zero_flag_q, .soft_reset_q,
    .reset_instruction_flag_n, .bank_q);

// file: tb/data_mem_model.sv
// behavioural data memory on the far side of the memory port
// assumes one-cycle strobes; read data stand only the cycle after
module data_mem_model (
    input  wire logic        ref_clk,
    input  wire logic [15:0] mem_addr_q,
    input  wire logic [7:0]  mem_wdata_q,
    input  wire logic        mem_we_q,
    input  wire logic        mem_re_q,
    output logic      [7:0]  mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];  // whole 16-bit space
    // fill with an address pattern the bench can predict
    initial begin
        mem_rdata = 8'h00;
        for (int a = 0; a < 65536; a++) mem[a] = a[7:0] ^ a[15:8] ^ 8'h3c;
    end
    // off-cycle data toggle so a late sample never matches by luck
    always @(posedge ref_clk) begin
        if (mem_we_q) mem[mem_addr_q] <= mem_wdata_q;
        mem_rdata <= mem_re_q ? mem[mem_addr_q] : ~mem_rdata;
    end
endmodule // data_mem_model

// file: tb/move_and_indirect_access_ops_bench.sv
// self-checking bench for the move / indirect access block
// assumes the data memory model answers the memory port
module move_and_indirect_access_ops_bench;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; $display("FAIL %0t got %h want %h", $time, a, b); end end
    logic        ref_clk = 1'b0, resetn = 1'b0, instr_valid = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
    logic [13:0] instr_data = 14'h0000;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00, r, d;
    logic [7:0]  wr [logic [15:0]];  // bytes stored so far
    wire         instr_ready_q, mem_we_q, mem_re_q, zero_flag_q, soft_reset_q, reset_instruction_flag_n;
    wire  [15:0] mem_addr_q;
    wire  [7:0]  mem_wdata_q, mem_rdata, acc_q, option_q, reg_rdata_q;
    wire  [4:0]  bank_q;
    int          n_mismatch = 0, n_tests = 0;
    logic [15:0] q;
    logic [4:0]  b;
    logic [6:0]  f;
    logic [3:0]  ra [7] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'hf}; // last one unmapped
    logic [7:0]  rv [7] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

    move_and_indirect_access_ops dut (.ref_clk, .resetn, .instr_valid, .instr_data, .instr_ready_q, .mem_addr_q,
        .mem_wdata_q, .mem_we_q, .mem_re_q, .mem_rdata, .acc_q, .zero_flag_q, .bank_q, .option_q, .soft_reset_q,
        .reset_instruction_flag_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata_q);
    data_mem_model mem (.ref_clk, .mem_addr_q, .mem_wdata_q, .mem_we_q, .mem_re_q, .mem_rdata);

    always #10 ref_clk = ~ref_clk;

    // expected byte: stored value or fill pattern
    function automatic logic [7:0] mval(input logic [15:0] a);
        return wr.exists(a) ? wr[a] : a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction

    task automatic test_done;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one register access, read data to r
    task automatic rw(input logic [3:0] a, input logic [7:0] v, input logic w);
        reg_addr <= a;
        reg_wdata <= v;
        reg_we <= w;
        reg_re <= !w;
        @(posedge ref_clk);
        reg_we <= 1'b0;
        reg_re <= 1'b0;
        @(posedge ref_clk);
        r = reg_rdata_q;
    endtask

    // offer an opcode, hold it until taken
    task automatic issue(input logic [13:0] op);
        int i;
        instr_valid <= 1'b1;
        instr_data <= op;
        for (i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            if (instr_ready_q === 1'b1) break;
        end
        if (i == 16) begin
            n_mismatch++;
            test_done;
        end
    endtask

    // one indirect move, pointer preset to v
    task automatic ind(input logic n, s, rel, input logic [1:0] m, input logic [5:0] o, input logic [15:0] v);
        logic [15:0] a, nx;
        nx = rel ? v : (m[0] ? v - 16'h0001 : v + 16'h0001);
        a = rel ? v + {{10{o[5]}}, o} : (m[1] ? v : nx);
        d = 8'($urandom);
        rw({2'h1, n, 1'b0}, v[7:0], 1'b1);
        rw({2'h1, n, 1'b1}, v[15:8], 1'b1);
        issue({6'h30, d});
        issue(rel ? {6'h3f, s, n, o} : {10'h001, s, n, m});
        instr_valid <= 1'b0;
        @(posedge ref_clk);
        `CHK({mem_addr_q, mem_we_q, mem_re_q}, {a, s, !s})
        if (s) begin
            `CHK(mem_wdata_q, d)
            wr[a] = d;
        end else begin
            d = mval(a);
            repeat (2) @(posedge ref_clk);
            `CHK({acc_q, zero_flag_q}, {d, d == 8'h00})
        end
        rw({2'h1, n, 1'b0}, 8'h00, 1'b0);
        a[7:0] = r;
        rw({2'h1, n, 1'b1}, 8'h00, 1'b0);
        a[15:8] = r;
        `CHK(a, nx)
    endtask

    initial begin
        void'($urandom(32'he59714e3));
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        // every mode, both pointers, wrap corners at 0000 and ffff
        for (int t = 0; t < 32; t++) ind(t[0], t[3], 1'b0, t[2:1], 6'h00, t[4] ? 16'($urandom) : {16{!t[1]}});
        $display("test pointer modes done");
        // offset form, -32 and 31 first
        for (int t = 0; t < 12; t++)
            ind(t[0], t[1] ^ t[3], 1'b1, 2'h0, t < 4 ? {!t[1], {5{t[1]}}} : 6'($urandom), 16'($urandom));
        $display("test offset form done");
        for (int t = 0; t < 8; t++) begin
            b = (t == 0) ? 5'h0f : 5'($urandom % 16);
            f = (t < 2) ? 7'(t) : 7'(2 + $urandom % 126);
            q = 16'($urandom);
            d = 8'($urandom);
            rw({2'h1, f[0], 1'b0}, q[7:0], 1'b1);
            rw({2'h1, f[0], 1'b1}, q[15:8], 1'b1);
            issue({9'h001, b});
            issue({6'h30, d});
            issue({7'h01, f});
            instr_valid <= 1'b0;
            @(posedge ref_clk);
            if (f > 7'h01) q = {4'h0, b, f};
            `CHK({mem_we_q, mem_addr_q, mem_wdata_q, bank_q}, {1'b1, q, d, b})
            wr[q] = d;
        end
        $display("test file move done");
        d = 8'($urandom);
        issue({6'h30, d});
        issue(14'h0062);
        issue(14'h0000);
        instr_valid <= 1'b0;
        @(posedge ref_clk);
        `CHK({mem_we_q, mem_re_q, acc_q, option_q}, {2'b00, d, d})
        $display("test option and idle done");
        issue(14'h0001);
        instr_valid <= 1'b0;
        @(posedge ref_clk);
        `CHK({soft_reset_q, reset_instruction_flag_n}, 2'b10)
        @(posedge ref_clk);
        foreach (ra[i]) begin
            rw(ra[i], 8'h00, 1'b0);
            `CHK(r, rv[i])
        end
        rw(4'h8, 8'h01, 1'b1);
        `CHK(reset_instruction_flag_n, 1'b1)
        $display("test software reset done");
        test_done;
    end
endmodule // move_and_indirect_access_ops_bench
